// *** verilog/sweep_params.svh ***
// Constants for the modulator and sweep control block
// Function
// - Reference clock drives modulator when selected
// - Reference phase inversion bit inverts modulator clock only when reference selected
// - Integer mode bypasses modulator, modulator keeps running
// - Sine select picks crystal sine source
// - Autoseed loads seed on fractional write
// - Order field picks modulator order
// - Quantizer output clamped to signed maximum
// - Quantizer output clamped to signed minimum
// - Clear bit asynchronously clears overflow flags
// - Sweep enable clear holds ramp logic in reset
// - Trigger write acts only from zero
// - Repeat mode retriggers ramps automatically
// - Start direction bit chooses first direction
// - External trigger taken from pin three
// - Single step advances once then holds
// - One direction mode hops back to start
// - 24-bit step count and step size
// - Repeat mode dwells after each ramp: at top and bottom, or only at the start in one direction mode
// - Integer divide part is 16 bits
// - Fractional divide part is 24 bits
// - Seed sets accumulator start phase
`ifndef SWEEP_PARAMS_SVH
`define SWEEP_PARAMS_SVH

`define OFS_INT_PART        5'h0f
`define OFS_FRAC_PART       5'h10
`define OFS_SEED            5'h11
`define OFS_MOD_CFG         5'h12
`define OFS_SWEEP_CTRL      5'h14
`define OFS_STEP_SIZE       5'h15
`define OFS_STEP_COUNT      5'h16
`define OFS_DWELL           5'h17
`define OFS_SWEEP_STATUS    5'h1f

`define RST_INT_PART        16'h00c8
`define RST_FRAC_PART       24'h000000
`define RST_SEED            24'h000000
`define RST_MOD_CFG         18'h21e82
`define RST_SWEEP_CTRL      8'h00
`define RST_STEP_SIZE       24'h000800
`define RST_STEP_COUNT      24'h000800
`define RST_DWELL           24'h000800

`define MC_REF_SEL          0
`define MC_CLK_INV          1
`define MC_REF_INV          2
`define MC_INT_MODE         3
`define MC_SIN_SEL          6
`define MC_AUTOSEED         7
`define MC_ORDER_LO         8
`define MC_QMAX_LO          10
`define MC_QMIN_LO          14

`define SC_CLEAR            0
`define SC_ENABLE           1
`define SC_TRIG             2
`define SC_REPEAT           3
`define SC_DOWN             4
`define SC_EXT_EN           5
`define SC_SINGLE_STEP      6
`define SC_ONE_DIR          7

`define ST_BUSY             0
`define ST_OVF              1
`define ST_UNDF             2

`endif

// *** verilog/sweep_pkg.sv ***
// Types shared by the modulator and sweep control block
package sweep_pkg;
    typedef enum logic [1:0] {
        ORD_FIRST    = 2'b00,
        ORD_SECOND   = 2'b01,
        ORD_THIRD_FB = 2'b10,
        ORD_THIRD_FF = 2'b11
    } mod_order_e;

    typedef enum logic [2:0] {
        SW_IDLE  = 3'b000,
        SW_STEP  = 3'b001,
        SW_DWELL = 3'b010,
        SW_HOLD  = 3'b011
    } sweep_state_e;
endpackage

// *** verilog/mod_link_if.sv ***
// Signals between the control logic and the modulator core
`timescale 1ns/1ps
`default_nettype none
interface mod_link_if;
    import sweep_pkg::*;
    logic              tick;        // One modulator clock edge
    mod_order_e        order;       // Modulator order
    logic [3:0]        qmax;        // Signed quantizer maximum
    logic [3:0]        qmin;        // Signed quantizer minimum
    logic              int_mode;    // Bypass modulator output
    logic [15:0]       int_part;    // Working integer part
    logic [23:0]       frac;        // Working fractional part
    logic [23:0]       seed;        // Seed value
    logic              seed_load;   // Load seed into accumulators
    logic [16:0]       div_value;   // Divide value to the divider
    logic [3:0]        quant;       // Clamped quantizer output

    modport ctrl (output tick, order, qmax, qmin, int_mode, int_part, frac, seed, seed_load,
                  input div_value, quant);
    modport core (input tick, order, qmax, qmin, int_mode, int_part, frac, seed, seed_load,
                  output div_value, quant);
endinterface
`default_nettype wire

// *** verilog/dsm_core.sv ***
// Delta-sigma modulator core: three cascaded accumulators with clamp
`timescale 1ns/1ps
`default_nettype none
module dsm_core
    import sweep_pkg::*;
(
    input  wire logic clk,      // System clock
    input  wire logic rstn,     // Asynchronous reset, active low
    input  wire logic clk_en,   // Freezes all state when low
    mod_link_if.core  lnk       // Configuration and results
);
    logic [23:0]      acc1_reg;
    logic [23:0]      acc2_reg;
    logic [23:0]      acc3_reg;
    logic             c2d_reg;
    logic             c3d_reg;
    logic             c3dd_reg;
    logic [24:0]      sum1;
    logic [24:0]      sum2;
    logic [24:0]      sum3;
    logic [23:0]      in2;
    logic [23:0]      in3;
    logic signed [4:0] raw;
    logic signed [4:0] clamped;

    // Feed-forward chains the new sums, feedback chains the stored ones
    always_comb
    begin
        sum1 = {1'b0, acc1_reg} + {1'b0, lnk.frac};
        in2  = (lnk.order == ORD_THIRD_FB) ? acc1_reg : sum1[23:0];
        sum2 = {1'b0, acc2_reg} + {1'b0, in2};
        in3  = (lnk.order == ORD_THIRD_FB) ? acc2_reg : sum2[23:0];
        sum3 = {1'b0, acc3_reg} + {1'b0, in3};
    end

    // Noise-shaped combination per order
    always_comb
    begin
        raw = {4'h0, sum1[24]};
        if (lnk.order != ORD_FIRST)
            raw = raw + {4'h0, sum2[24]} - {4'h0, c2d_reg};
        if (lnk.order == ORD_THIRD_FB || lnk.order == ORD_THIRD_FF)
            raw = raw + {4'h0, sum3[24]} - {3'h0, c3d_reg, 1'b0} + {4'h0, c3dd_reg};
        clamped = raw;
        if (raw > $signed({lnk.qmax[3], lnk.qmax}))
            clamped = $signed({lnk.qmax[3], lnk.qmax});
        if (raw < $signed({lnk.qmin[3], lnk.qmin}))
            clamped = $signed({lnk.qmin[3], lnk.qmin});
    end

    // Accumulators advance only on modulator edges; seed loads the start phase
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            acc1_reg <= 24'h000000;
            acc2_reg <= 24'h000000;
            acc3_reg <= 24'h000000;
            c2d_reg  <= 1'b0;
            c3d_reg  <= 1'b0;
            c3dd_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (lnk.seed_load)
            begin
                acc1_reg <= lnk.seed;
                acc2_reg <= 24'h000000;
                acc3_reg <= 24'h000000;
                c2d_reg  <= 1'b0;
                c3d_reg  <= 1'b0;
                c3dd_reg <= 1'b0;
            end
            else if (lnk.tick)
            begin
                acc1_reg <= sum1[23:0];
                acc2_reg <= sum2[23:0];
                acc3_reg <= sum3[23:0];
                c2d_reg  <= sum2[24];
                c3d_reg  <= sum3[24];
                c3dd_reg <= c3d_reg;
            end
        end
    end

    // Divider word; integer mode ignores the quantizer but keeps it running
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lnk.div_value <= 17'h00000;
            lnk.quant     <= 4'h0;
        end
        else if (clk_en && lnk.tick)
        begin
            lnk.quant <= clamped[3:0];
            if (lnk.int_mode)
                lnk.div_value <= {1'b0, lnk.int_part};
            else
                lnk.div_value <= {1'b0, lnk.int_part} + {{13{clamped[3]}}, clamped[3:0]};
        end
    end
endmodule
`default_nettype wire

// *** verilog/sigma_delta_sweep_control.sv ***
// Register file, modulator clocking and linear sweeper
`timescale 1ns/1ps
`default_nettype none
`include "sweep_params.svh"
module sigma_delta_sweep_control
    import sweep_pkg::*;
(
    input  wire logic        clk,                   // System clock, 250 MHz
    input  wire logic        rstn,                  // Asynchronous reset, active low
    input  wire logic        clk_en,                // Freezes all state when low
    input  wire logic        reg_wr,                // Register write strobe
    input  wire logic [4:0]  reg_addr,              // Register index
    input  wire logic [23:0] reg_wdata,             // Write data
    output logic      [23:0] reg_rdata,             // Read data, registered
    input  wire logic        ref_clk_in,            // Divided reference clock, sampled
    input  wire logic        div_clk_in,            // Divided feedback clock, sampled
    input  wire logic        xref_path_sel,         // Crystal path selected as reference
    input  wire logic        xref_sq_in,            // Squared crystal clock, sampled
    input  wire logic        xref_sin_in,           // Sine crystal clock, sampled
    input  wire logic        general_out_pin_three, // Hardware sweep trigger pin
    output logic      [16:0] div_value,             // Divide value to the feedback divider
    output logic      [3:0]  quant_out,             // Clamped quantizer output
    output logic             sweep_busy,            // Ramp in progress
    output logic             sweep_ovf,             // Sweep overflow flag
    output logic             sweep_undf             // Sweep underflow flag
);
    mod_link_if lnk ();

    logic [15:0]  int_part_reg;
    logic [23:0]  frac_part_reg;
    logic [23:0]  seed_reg;
    logic [17:0]  mod_cfg_reg;
    logic [7:0]   sweep_ctrl_reg;
    logic [23:0]  step_size_reg;
    logic [23:0]  step_count_reg;
    logic [23:0]  dwell_reg;
    logic         wr_ctrl;
    logic         sw_trig;
    logic         mclk_prev_reg;
    logic         mclk_src;
    logic         pin_prev_reg;
    logic         ext_trig;
    logic         trigger;
    sweep_state_e state_reg;
    sweep_state_e state_next;
    logic [39:0]  ramp_reg;
    logic [39:0]  start_reg;
    logic [23:0]  steps_left_reg;
    logic [23:0]  dwell_left_reg;
    logic         down_reg;
    logic [40:0]  ramp_sum;
    logic         last_step;
    logic         step_go;
    logic         flag_rstn;
    logic         ovf_set;
    logic         undf_set;

    ////////////////////////////////////////////////////////////////////////////
    // Register writes

    assign wr_ctrl = clk_en && reg_wr && (reg_addr == `OFS_SWEEP_CTRL);
    // A write only triggers when the stored trigger bit was still clear
    assign sw_trig = wr_ctrl && reg_wdata[`SC_TRIG] && !sweep_ctrl_reg[`SC_TRIG];

    // Configuration registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            int_part_reg   <= `RST_INT_PART;
            frac_part_reg  <= `RST_FRAC_PART;
            seed_reg       <= `RST_SEED;
            mod_cfg_reg    <= `RST_MOD_CFG;
            sweep_ctrl_reg <= `RST_SWEEP_CTRL;
            step_size_reg  <= `RST_STEP_SIZE;
            step_count_reg <= `RST_STEP_COUNT;
            dwell_reg      <= `RST_DWELL;
        end
        else if (clk_en && reg_wr)
        begin
            case (reg_addr)
                `OFS_INT_PART:   int_part_reg   <= reg_wdata[15:0];
                `OFS_FRAC_PART:  frac_part_reg  <= reg_wdata;
                `OFS_SEED:       seed_reg       <= reg_wdata;
                `OFS_MOD_CFG:    mod_cfg_reg    <= reg_wdata[17:0];
                `OFS_SWEEP_CTRL: sweep_ctrl_reg <= reg_wdata[7:0];
                `OFS_STEP_SIZE:  step_size_reg  <= reg_wdata;
                `OFS_STEP_COUNT: step_count_reg <= reg_wdata;
                `OFS_DWELL:      dwell_reg      <= reg_wdata;
                default:         ;
            endcase
        end
    end

    // Read-back; unmapped indices read zero
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            reg_rdata <= 24'h000000;
        else if (clk_en)
        begin
            case (reg_addr)
                `OFS_INT_PART:     reg_rdata <= {8'h00, int_part_reg};
                `OFS_FRAC_PART:    reg_rdata <= frac_part_reg;
                `OFS_SEED:         reg_rdata <= seed_reg;
                `OFS_MOD_CFG:      reg_rdata <= {6'h00, mod_cfg_reg};
                `OFS_SWEEP_CTRL:   reg_rdata <= {16'h0000, sweep_ctrl_reg};
                `OFS_STEP_SIZE:    reg_rdata <= step_size_reg;
                `OFS_STEP_COUNT:   reg_rdata <= step_count_reg;
                `OFS_DWELL:        reg_rdata <= dwell_reg;
                `OFS_SWEEP_STATUS: reg_rdata <= {21'h000000, sweep_undf, sweep_ovf, sweep_busy};
                default:           reg_rdata <= 24'h000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Modulator clock selection

    // Pick the reference, crystal sine or squared, or the feedback clock
    always_comb
    begin
        if (mod_cfg_reg[`MC_REF_SEL])
        begin
            if (xref_path_sel)
                mclk_src = mod_cfg_reg[`MC_SIN_SEL] ? xref_sin_in : xref_sq_in;
            else
                mclk_src = ref_clk_in;
            mclk_src = mclk_src ^ mod_cfg_reg[`MC_REF_INV];
        end
        else
            mclk_src = div_clk_in;
        mclk_src = mclk_src ^ mod_cfg_reg[`MC_CLK_INV];
    end

    // Inputs are synchronous, so one stored copy gives a clean edge
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mclk_prev_reg <= 1'b0;
            pin_prev_reg  <= 1'b0;
        end
        else if (clk_en)
        begin
            mclk_prev_reg <= mclk_src;
            pin_prev_reg  <= general_out_pin_three;
        end
    end

    assign lnk.tick = mclk_src && !mclk_prev_reg;
    assign ext_trig = sweep_ctrl_reg[`SC_EXT_EN] && general_out_pin_three && !pin_prev_reg;
    assign trigger  = sw_trig || ext_trig;

    ////////////////////////////////////////////////////////////////////////////
    // Sweeper state machine

    // Sweep value is {integer, fraction}; a carry or borrow leaves the range
    assign ramp_sum  = down_reg ? ({1'b0, ramp_reg} - {17'h00000, step_size_reg})
                                : ({1'b0, ramp_reg} + {17'h00000, step_size_reg});
    assign step_go   = (state_reg == SW_STEP) && lnk.tick;
    assign last_step = (steps_left_reg <= 24'h000001);

    // Next state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            SW_IDLE:
                if (trigger)
                    state_next = SW_STEP;
            SW_STEP:
                if (step_go)
                begin
                    if (sweep_ctrl_reg[`SC_SINGLE_STEP])
                        state_next = SW_IDLE;
                    else if (last_step)
                        state_next = sweep_ctrl_reg[`SC_REPEAT] ? SW_DWELL : SW_HOLD;
                end
            SW_DWELL:
                if (lnk.tick && dwell_left_reg <= 24'h000001)
                    state_next = SW_STEP;
            SW_HOLD:
                state_next = SW_IDLE;
            default:
                state_next = SW_IDLE;
        endcase
        if (!sweep_ctrl_reg[`SC_ENABLE])
            state_next = SW_IDLE;
    end

    // State register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state_reg <= SW_IDLE;
        else if (clk_en)
            state_reg <= state_next;
    end

    // Ramp value, direction and counters
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ramp_reg       <= 40'h0000000000;
            start_reg      <= 40'h0000000000;
            steps_left_reg <= 24'h000000;
            dwell_left_reg <= 24'h000000;
            down_reg       <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!sweep_ctrl_reg[`SC_ENABLE])
            begin
                // Held in reset: track the programmed word, restore direction
                ramp_reg <= {int_part_reg, frac_part_reg};
                // Take a direction written with the enable, not the stale one
                down_reg <= wr_ctrl ? reg_wdata[`SC_DOWN] : sweep_ctrl_reg[`SC_DOWN];
            end
            else if (state_reg == SW_IDLE && trigger)
            begin
                start_reg      <= ramp_reg;
                steps_left_reg <= step_count_reg;
                if (sweep_ctrl_reg[`SC_ONE_DIR])
                    down_reg <= sweep_ctrl_reg[`SC_DOWN];
            end
            else if (step_go)
            begin
                ramp_reg       <= ramp_sum[39:0];
                steps_left_reg <= steps_left_reg - 24'h000001;
                if (last_step && !sweep_ctrl_reg[`SC_SINGLE_STEP])
                begin
                    dwell_left_reg <= dwell_reg;
                    if (sweep_ctrl_reg[`SC_ONE_DIR])
                        ramp_reg <= start_reg;
                    else
                        down_reg <= !down_reg; // Next ramp runs the other way
                end
            end
            else if (state_reg == SW_DWELL && lnk.tick)
            begin
                dwell_left_reg <= dwell_left_reg - 24'h000001;
                if (dwell_left_reg <= 24'h000001)
                    steps_left_reg <= step_count_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Range flags

    // Clear bit acts without the clock; it wins while it stays high
    assign flag_rstn = rstn && !sweep_ctrl_reg[`SC_CLEAR];
    assign ovf_set   = step_go && !down_reg && ramp_sum[40];
    assign undf_set  = step_go && down_reg && ramp_sum[40];

    always_ff @(posedge clk or negedge flag_rstn)
    begin
        if (!flag_rstn)
        begin
            sweep_ovf  <= 1'b0;
            sweep_undf <= 1'b0;
        end
        else if (clk_en)
        begin
            if (ovf_set)
                sweep_ovf <= 1'b1;
            if (undf_set)
                sweep_undf <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Modulator hookup

    // Autoseed fires on each fractional write
    assign lnk.seed_load = clk_en && reg_wr && (reg_addr == `OFS_FRAC_PART)
                           && mod_cfg_reg[`MC_AUTOSEED];
    assign lnk.order     = mod_order_e'(mod_cfg_reg[`MC_ORDER_LO +: 2]);
    assign lnk.qmax      = mod_cfg_reg[`MC_QMAX_LO +: 4];
    assign lnk.qmin      = mod_cfg_reg[`MC_QMIN_LO +: 4];
    assign lnk.int_mode  = mod_cfg_reg[`MC_INT_MODE];
    assign lnk.seed      = seed_reg;
    // Span limits are software's duty; wrap is only flagged, not prevented
    assign lnk.int_part  = sweep_ctrl_reg[`SC_ENABLE] ? ramp_reg[39:24] : int_part_reg;
    assign lnk.frac      = sweep_ctrl_reg[`SC_ENABLE] ? ramp_reg[23:0] : frac_part_reg;

    dsm_core u_core (
        .clk    (clk),
        .rstn   (rstn),
        .clk_en (clk_en),
        .lnk    (lnk)
    );

    assign div_value  = lnk.div_value;
    assign quant_out  = lnk.quant;
    assign sweep_busy = (state_reg != SW_IDLE);
endmodule
`default_nettype wire

// *** dv/sweep_checker.sv ***
// Port checker for the modulator and sweep control block
`timescale 1ns/1ps
`default_nettype none
`include "sweep_params.svh"
module sweep_checker (
    input wire logic        clk, // Clock
    input wire logic        rstn, // Reset, active low
    input wire logic        clk_en, // Enable
    input wire logic        reg_wr, // Write strobe
    input wire logic [4:0]  reg_addr, // Index
    input wire logic [23:0] reg_wdata, // Write data
    input wire logic [23:0] reg_rdata, // Read data
    input wire logic        general_out_pin_three, // Trigger pin
    input wire logic [16:0] div_value, // Divide value
    input wire logic [3:0]  quant_out, // Quantizer
    input wire logic        sweep_busy, // Busy
    input wire logic        sweep_ovf, // Overflow
    input wire logic        sweep_undf // Underflow
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [7:0]  sc_q;  // Sweep control copy
    logic [17:0] mc_q;  // Modulator config copy
    logic [15:0] int_q; // Integer part copy
    logic        wr_sc; // Write to sweep control
    ////////////////////////////////////////
    // Shadows of the stored bits
    assign wr_sc = reg_wr && clk_en && reg_addr == `OFS_SWEEP_CTRL;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sc_q  <= `RST_SWEEP_CTRL;
            mc_q  <= `RST_MOD_CFG;
            int_q <= `RST_INT_PART;
        end
        else if (reg_wr && clk_en)
        begin
            if (reg_addr == `OFS_SWEEP_CTRL) sc_q <= reg_wdata[7:0];
            if (reg_addr == `OFS_MOD_CFG) mc_q <= reg_wdata[17:0];
            if (reg_addr == `OFS_INT_PART) int_q <= reg_wdata[15:0];
        end
    end
    ////////////////////////////////////////
    // Pin triggers excluded
    a_trig_starts_busy: assert property (
        wr_sc && reg_wdata[2:1] == 2'b11 && !sc_q[2] && !sweep_busy |=> sweep_busy)
        else $error("trigger ignored");
    a_retrig_refused: assert property (
        wr_sc && sc_q[2] && !sc_q[5] && !sc_q[3] && !reg_wdata[3] && !sweep_busy
        |=> !sweep_busy) else $error("retrigger accepted");
    a_disabled_idle: assert property (
        !sc_q[1] && !$past(sc_q[1]) && $past(clk_en) |-> !sweep_busy)
        else $error("busy while sweep disabled");
    a_clear_flags: assert property (
        sc_q[0] |-> !sweep_ovf && !sweep_undf) else $error("flags not cleared");
    a_quant_max: assert property (
        $changed(quant_out) |-> $signed(quant_out) <= $signed($past(mc_q[13:10])))
        else $error("quantizer above maximum");
    a_quant_min: assert property (
        $changed(quant_out) |-> $signed(quant_out) >= $signed($past(mc_q[17:14])))
        else $error("quantizer below minimum");
    a_int_bypass: assert property (
        $changed(div_value) && mc_q[3] && !sc_q[1] && $past(mc_q, 3) == mc_q
        && $past(int_q, 3) == int_q |-> div_value == {1'b0, int_q})
        else $error("bypass value wrong");
    a_status_view: assert property (
        $past(clk_en) && $past(reg_addr) == `OFS_SWEEP_STATUS |-> reg_rdata ==
        {21'h0, $past(sweep_undf), $past(sweep_ovf), $past(sweep_busy)})
        else $error("status read wrong");
    c_trigger: cover property (wr_sc && reg_wdata[2:1] == 2'b11 && !sc_q[2]);
    c_overflow: cover property ($rose(sweep_ovf));
    c_int_mode: cover property (mc_q[3] && $changed(div_value));
endmodule
bind sigma_delta_sweep_control sweep_checker u_chk (.*);
`default_nettype wire

// *** dv/sigma_delta_sweep_control_tb.sv ***
// Self-checking bench for the modulator and sweep control block
`timescale 1ns/1ps
`default_nettype none
`include "sweep_params.svh"
module sigma_delta_sweep_control_tb;
    logic        clk = 0, rstn = 0, clk_en = 1, reg_wr = 0, xref_path_sel = 0, pin = 0;
    logic        ref_clk_in = 0, div_clk_in = 0, xref_sq_in = 0, xref_sin_in = 0;
    logic [4:0]  reg_addr = 0;
    logic [23:0] reg_wdata = 0, reg_rdata;
    logic [16:0] div_value;
    logic [3:0]  quant_out;
    logic        sweep_busy, sweep_ovf, sweep_undf;
    logic [3:0]  src_on = 0;  // Running slow clocks: div, ref, sq, sin
    logic [2:0]  src_cnt = 0;
    logic [31:0] rnd = 32'h8e6cccb8;
    logic [23:0] mdl [0:31];  // Expected register contents
    logic [15:0] int_v;
    longint      base, st = 64'h400000;
    int          mismatches = 0, n_checks = 0;
    logic [28:0] rtab [10] = '{{`OFS_INT_PART, 8'h0, `RST_INT_PART},
        {`OFS_FRAC_PART, `RST_FRAC_PART}, {`OFS_SEED, `RST_SEED},
        {`OFS_MOD_CFG, 6'h0, `RST_MOD_CFG}, {`OFS_SWEEP_CTRL, 16'h0, `RST_SWEEP_CTRL},
        {`OFS_STEP_SIZE, `RST_STEP_SIZE}, {`OFS_STEP_COUNT, `RST_STEP_COUNT},
        {`OFS_DWELL, `RST_DWELL}, {5'h13, 24'h0}, {`OFS_SWEEP_STATUS, 24'h0}};

    sigma_delta_sweep_control dut (.*, .general_out_pin_three(pin));
    ////////////////////////////////////////
    // Clock and slow sources; stopped ones give no ticks
    initial
    begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        src_cnt <= src_cnt + 3'd1;
        if (src_cnt[1:0] == 2'd3)
            {xref_sin_in, xref_sq_in, ref_clk_in, div_clk_in} <=
                {xref_sin_in, xref_sq_in, ref_clk_in, div_clk_in} ^ src_on;
    end
    ////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [23:0] msk(input logic [4:0] a);
        case (a)
            5'h0f: return 24'h00ffff;
            5'h12: return 24'h03ffff;
            5'h14: return 24'h0000ff;
            5'h10, 5'h11, 5'h15, 5'h16, 5'h17: return 24'hffffff;
            default: return 24'h000000;
        endcase
    endfunction
    // Ramp model: integer part after n steps
    function automatic logic [16:0] exp_int(input longint w, input longint s, input int n);
        return 17'((w + s * n) >>> 24);
    endfunction
    task automatic check(input logic [39:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        mdl[a] = d & msk(a);
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge clk);
        reg_addr <= a;
        repeat (2) @(posedge clk);
        #1 check(reg_rdata, mdl[a]);
    endtask
    task automatic trig(input logic [7:0] c);
        wr(5'h14, {16'h0, c});
        wr(5'h14, {16'h0, c | 8'h04});
        #1 check(sweep_busy, 1'b1);
    endtask
    // Slack for the last tick
    task automatic ramp(input logic [7:0] c, input logic [16:0] e);
        trig(c);
        for (int i = 0; i < 3000 && sweep_busy; i++) @(posedge clk);
        repeat (20) @(posedge clk);
        #1 check(sweep_busy, 1'b0);
        check(div_value, e);
        check(quant_out, 4'h0);
    endtask
    task automatic off;
        wr(5'h14, 24'h0);
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        foreach (rtab[i])
        begin
            mdl[rtab[i][28:24]] = rtab[i][23:0];
            rd(rtab[i][28:24]);
        end
        foreach (rtab[i])
        begin
            rnd = xs(rnd);
            if (rtab[i][28:24] != 5'h14) wr(rtab[i][28:24], rnd[23:0]);
            rd(rtab[i][28:24]);
        end
        int_v = 16'h0100 + 16'(rnd[27:20]);
        wr(5'h0f, {8'h0, int_v});
        wr(5'h10, 24'h5a5a5a);
        src_on = 4'b0001;
        for (int o = 0; o < 4; o++)
        begin
            wr(5'h12, 24'h030c80 | 24'(o << 8));
            repeat (40) @(posedge clk);
            rd(5'h12);
        end
        wr(5'h12, 24'h030c88);
        repeat (40) @(posedge clk);
        check(div_value, {1'b0, int_v});
        // Zero clamp: divide value is the ramp's integer
        wr(5'h10, 24'hc00000);
        wr(5'h12, 24'h000280);
        wr(5'h15, 24'h400000);
        wr(5'h16, 24'h000004);
        wr(5'h17, 24'h000003);
        base = {int_v, 24'hc00000};
        ramp(8'h02, exp_int(base, st, 4));
        wr(5'h14, 24'h000006);
        #1 check(sweep_busy, 1'b0);
        ramp(8'h02, exp_int(base, st, 0));
        off;
        ramp(8'h12, exp_int(base, -st, 4));
        off;
        ramp(8'h82, exp_int(base, st, 0));
        wr(5'h10, 24'h800000);
        base = {int_v, 24'h800000};
        off;
        ramp(8'h42, exp_int(base, st, 1));
        off;
        wr(5'h12, 24'h000281);
        src_on = 4'b0010;
        ramp(8'h02, exp_int(base, st, 4));
        off;
        wr(5'h12, 24'h0002c1);
        xref_path_sel <= 1'b1;
        src_on = 4'b1000;
        ramp(8'h02, exp_int(base, st, 4));
        wr(5'h12, 24'h000280);
        src_on = 4'b0001;
        off;
        wr(5'h14, 24'h000022);
        pin <= 1'b1;
        repeat (4) @(posedge clk);
        #1 check(sweep_busy, 1'b1);
        off;
        trig(8'h0a);
        repeat (400) @(posedge clk);
        #1 check(sweep_busy, 1'b1);
        off;
        repeat (2) @(posedge clk);
        #1 check(sweep_busy, 1'b0);
        wr(5'h0f, 24'h00ffff);
        wr(5'h10, 24'hc00000);
        ramp(8'h02, 17'h00000);
        check(sweep_ovf, 1'b1);
        wr(5'h14, 24'h000001);
        #1 check(sweep_ovf, 1'b0);
        wr(5'h0f, 24'h0);
        wr(5'h10, 24'h0);
        off;
        trig(8'h12);
        repeat (200) @(posedge clk);
        check(sweep_undf, 1'b1);
        tally_and_finish;
    end
    // Watchdog, far above the run's length
    initial
    begin
        repeat (60000) @(posedge clk);
        mismatches++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
